// File: logic/pag_port.sv
// Purpose: Eight-pin general-purpose port with pin sharing
// Assumes: Register accesses arrive as one-cycle strobes on clk
// Notes:   Pin reads pass a three-flop synchroniser before use
//
// Function
// - Direction bit one makes the pin an input, driver off.
// - Direction bit zero drives the pin from the latch bit.
// - Pin-level read returns pins; pin-level write updates the latch.
// - Latch register is separate; its read returns the latch value.
// - Eight pins, each with own direction, latch and read bit.
// - Top pins are port pins only if oscillator frees them, else zero.
// - Five analog select bits for pins 0-3 and 5, set at reset.
// - After reset analog pins read zero; pin four is digital input.
// - Analog select kills the pin-level read only, not the latch output.
// - Direction bits drive pins even in analog use; keep them set.
// - Routed comparator output drives pin four or five when output.
// - Reference output on pin two disables its digital in and out.
// - Pin six is I/O in free modes, cycle clock out in clock-out modes.
// - Pin four feeds the first timer clock input.
// - Pin five feeds the serial slave select input.
// - Pin seven is port I/O only in the two internal oscillator modes.
`timescale 1ns/1ps
`default_nettype none

module pag_port (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Register strobes
  input  wire logic       pin_level_reg_wr,
  input  wire logic       output_latch_reg_wr,
  input  wire logic       direction_reg_wr,
  input  wire logic       analog_select_reg_wr,
  input  wire logic [7:0] wr_data,
  // Configuration and peripherals
  input  wire logic [2:0] osc_mode,
  input  wire logic       first_comparator_oe,
  input  wire logic       first_comparator_out,
  input  wire logic       second_comparator_oe,
  input  wire logic       second_comparator_out,
  input  wire logic       comparator_ref_voltage_oe,
  // Pins
  input  wire logic [7:0] pad_in,
  output logic      [7:0] pad_out,
  output logic      [7:0] pad_oe,
  // Register read-back
  output logic      [7:0] pin_level_reg,
  output logic      [7:0] output_latch_reg,
  output logic      [7:0] direction_reg,
  output logic      [4:0] analog_select_bits,
  // Peripheral inputs
  output logic            first_timer_clock_in,
  output logic            serial_slave_select_n
);

  // ==========================================================
  // Stored state
  logic [7:0] latch_ff;
  logic [7:0] dir_ff;
  logic [4:0] analog_select_reg_ff;
  logic [7:0] s1_ff, s2_ff, s3_ff, pin_ff;
  logic [1:0] div_ff;
  logic       cyc_ff;

  // ==========================================================
  // Pin ownership by oscillator mode
  logic free6, free7, clko6;
  always_comb begin
    free6 = (osc_mode == pag_pkg::PAG_OSC_RC_IO) ||
            (osc_mode == pag_pkg::PAG_OSC_INT_IO) ||
            (osc_mode == pag_pkg::PAG_OSC_EXT_IO);
    clko6 = (osc_mode == pag_pkg::PAG_OSC_RC_CLKO) ||
            (osc_mode == pag_pkg::PAG_OSC_INT_CLKO) ||
            (osc_mode == pag_pkg::PAG_OSC_EXT_CLKO);
    // Only the internal oscillator modes leave the input pin free
    free7 = (osc_mode == pag_pkg::PAG_OSC_INT_IO) ||
            (osc_mode == pag_pkg::PAG_OSC_INT_CLKO);
  end

  logic [7:0] io_en;
  assign io_en = {free7, free6, 6'h3f};

  // Analog select per pin: bits map to pins 0-3 and 5
  logic [7:0] ana;
  assign ana = {2'h0, analog_select_reg_ff[4], 1'b0, analog_select_reg_ff[3:0]};

  // ==========================================================
  // Registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_ff <= pag_pkg::PAG_LATCH_RST;
    end else if (pin_level_reg_wr || output_latch_reg_wr) begin
      latch_ff <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_ff <= pag_pkg::PAG_DIR_RST;
    end else if (direction_reg_wr) begin
      dir_ff <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_select_reg_ff <= pag_pkg::PAG_ANALOG_SELECT_REG_RST;
    end else if (analog_select_reg_wr) begin
      analog_select_reg_ff <= wr_data[4:0];
    end
  end

  // ==========================================================
  // Synchroniser; change counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff  <= 8'h00;
      s2_ff  <= 8'h00;
      s3_ff  <= 8'h00;
      pin_ff <= 8'h00;
    end else begin
      s1_ff <= pad_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      pin_ff <= (s2_ff & s3_ff) | (~(s2_ff ^ s3_ff) & s3_ff) |
                ((s2_ff ^ s3_ff) & pin_ff);
    end
  end

  // ==========================================================
  // Cycle clock: system clock divided by four
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= 2'h0;
      cyc_ff <= 1'b0;
    end else begin
      div_ff <= (div_ff == pag_pkg::PAG_DIV_LAST) ? 2'h0 : div_ff + 2'h1;
      cyc_ff <= (div_ff >= pag_pkg::PAG_DIV_HALF);
    end
  end

  // ==========================================================
  // Per-pin output and read paths
  logic [7:0] nxt_out, nxt_oe, nxt_rd;
  genvar g;
  generate
    for (g = 0; g < pag_pkg::PAG_WIDTH; g++) begin : g_pin
      logic vref_here;
      logic cmp_on;
      logic cmp_val;
      logic clko_here;
      logic pin_oe;
      logic pin_out;

      // Reference output owns pin two whatever the direction bit says
      assign vref_here = (g == pag_pkg::PAG_PIN_VREF) &&
                         comparator_ref_voltage_oe;

      // Comparator routing exists only on pins four and five
      always_comb begin
        cmp_on  = 1'b0;
        cmp_val = 1'b0;
        if (g == pag_pkg::PAG_PIN_T1CKI) begin
          cmp_on  = first_comparator_oe;
          cmp_val = first_comparator_out;
        end else if (g == pag_pkg::PAG_PIN_SEL) begin
          cmp_on  = second_comparator_oe;
          cmp_val = second_comparator_out;
        end
      end

      assign clko_here = (g == pag_pkg::PAG_PIN_CLKO) && clko6;

      always_comb begin
        // Direction bit still steers the driver in analog use
        pin_oe  = io_en[g] && !dir_ff[g] && !vref_here;
        pin_out = latch_ff[g];
        // Comparator result takes priority over the latch bit
        if (cmp_on) begin
          pin_out = cmp_val;
        end
        if (clko_here) begin
          pin_oe  = 1'b1;
          pin_out = cyc_ff;
        end
        // A released pin shows zero rather than a stale latch bit
        if (!pin_oe) begin
          pin_out = 1'b0;
        end
      end

      assign nxt_oe[g]  = pin_oe;
      assign nxt_out[g] = pin_out;
      // Analog select blocks the digital input only
      assign nxt_rd[g]  = pin_ff[g] && !ana[g] && io_en[g] &&
                          !vref_here;
    end
  endgenerate

  // ==========================================================
  // Registered outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_out               <= 8'h00;
      pad_oe                <= 8'h00;
      pin_level_reg         <= 8'h00;
      output_latch_reg      <= pag_pkg::PAG_LATCH_RST;
      direction_reg         <= pag_pkg::PAG_DIR_RST & 8'h3f;
      analog_select_bits    <= pag_pkg::PAG_ANALOG_SELECT_REG_RST;
      first_timer_clock_in  <= 1'b0;
      serial_slave_select_n <= 1'b0;
    end else begin
      pad_out               <= nxt_out;
      pad_oe                <= nxt_oe;
      pin_level_reg         <= nxt_rd;
      output_latch_reg      <= latch_ff & io_en;
      direction_reg         <= dir_ff & io_en;
      analog_select_bits    <= analog_select_reg_ff;
      // Timer input bypasses analog gating: pin four is never analog
      first_timer_clock_in  <= pin_ff[pag_pkg::PAG_PIN_T1CKI];
      serial_slave_select_n <= pin_ff[pag_pkg::PAG_PIN_SEL];
    end
  end

endmodule // pag_port

`default_nettype wire

// File: logic/pag_pkg.sv
// Purpose: Constants for the eight-pin port with pin sharing
// Assumes: Single 100 MHz clock domain
// Notes:   Oscillator configuration codes are local choices
package pag_pkg;
  localparam int          PAG_WIDTH         = 8;
  localparam logic [7:0]  PAG_DIR_RST       = 8'hff;
  localparam logic [7:0]  PAG_LATCH_RST     = 8'h00;
  localparam logic [4:0]  PAG_ANALOG_SELECT_REG_RST     = 5'h1f;
  localparam int          PAG_PIN_T1CKI     = 4;
  localparam int          PAG_PIN_SEL       = 5;
  localparam int          PAG_PIN_CLKO      = 6;
  localparam int          PAG_PIN_OSCIN     = 7;
  localparam int          PAG_PIN_VREF      = 2;
  localparam int          PAG_CYC_DIV       = 4;
  localparam logic [1:0]  PAG_DIV_LAST      = 2'h3;
  localparam logic [1:0]  PAG_DIV_HALF      = 2'h2;
  // Oscillator configuration codes
  localparam logic [2:0]  PAG_OSC_XTAL      = 3'h0;
  localparam logic [2:0]  PAG_OSC_RC_IO     = 3'h1;
  localparam logic [2:0]  PAG_OSC_RC_CLKO   = 3'h2;
  localparam logic [2:0]  PAG_OSC_INT_IO    = 3'h3;
  localparam logic [2:0]  PAG_OSC_INT_CLKO  = 3'h4;
  localparam logic [2:0]  PAG_OSC_EXT_IO    = 3'h5;
  localparam logic [2:0]  PAG_OSC_EXT_CLKO  = 3'h6;
endpackage : pag_pkg

// File: bench/pag_checker.sv
// Purpose: Port-level checks for pag_port
// Assumes: Read-back one edge after the strobe edge; pin reads five edges after a level change
// Notes:   Bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module pag_checker (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Control
  input wire logic       pin_level_reg_wr,
  input wire logic       output_latch_reg_wr,
  input wire logic [7:0] wr_data,
  input wire logic [2:0] osc_mode,
  input wire logic       comparator_ref_voltage_oe,
  // Pins and read-back
  input wire logic [7:0] pad_in,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pin_level_reg,
  input wire logic [7:0] output_latch_reg,
  input wire logic [7:0] direction_reg,
  input wire logic [4:0] analog_select_bits,
  input wire logic       first_timer_clock_in,
  input wire logic       serial_slave_select_n
);
  // ==========================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_DIR_OFF: assert property (
    ~|(direction_reg[5:0] & pad_oe[5:0]))
    else $error("driver on for an input pin");
  AST_DRIVE: assert property (
    !direction_reg[0] |-> pad_oe[0] &&
    pad_out[0] == output_latch_reg[0])
    else $error("pin 0 not latch");
  // Latch takes the strobe edge; read-back follows one edge later
  AST_PIN_WR: assert property (
    pin_level_reg_wr |-> ##2
    output_latch_reg[5:0] == $past(wr_data[5:0], 2))
    else $error("pin write");
  AST_LAT_WR: assert property (
    output_latch_reg_wr |-> ##2
    output_latch_reg[5:0] == $past(wr_data[5:0], 2))
    else $error("latch write");
  AST_TOP_MASK: assert property (
    (osc_mode == pag_pkg::PAG_OSC_XTAL)[*8] |->
    pin_level_reg[7:6] == 2'h0 && direction_reg[7:6] == 2'h0)
    else $error("top pins not masked");
  AST_ANA_IN: assert property (
    analog_select_bits[0][*7] |-> !pin_level_reg[0])
    else $error("analog pin reads high");
  AST_VREF: assert property (
    comparator_ref_voltage_oe[*2] |-> !pad_oe[2])
    else $error("pin 2 driven under reference");
  AST_CLKO: assert property (
    (osc_mode == pag_pkg::PAG_OSC_RC_CLKO ||
     osc_mode == pag_pkg::PAG_OSC_INT_CLKO ||
     osc_mode == pag_pkg::PAG_OSC_EXT_CLKO)[*4] |->
    pad_oe[6] && pad_out[6] != $past(pad_out[6], 2))
    else $error("cycle clock");
  AST_PERIPH: assert property (
    $stable(pad_in[5:4])[*7] |->
    {serial_slave_select_n, first_timer_clock_in} == pad_in[5:4])
    else $error("peripheral input");
endmodule // pag_checker
bind pag_port pag_checker u_chk (.clk, .rst_n, .pin_level_reg_wr,
  .output_latch_reg_wr, .wr_data, .osc_mode, .comparator_ref_voltage_oe,
  .pad_in, .pad_out, .pad_oe, .pin_level_reg, .output_latch_reg,
  .direction_reg, .analog_select_bits, .first_timer_clock_in,
  .serial_slave_select_n);
`default_nettype wire

// File: bench/pag_board.sv
// Purpose: Board signals on the port pins
// Assumes: Board sources are weaker than the device drivers
// Notes:   Undriven pins show the board level, never a stale value
`timescale 1ns/1ps
`default_nettype none
module pag_board (
  // Device side
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  // Board side
  input  wire logic [7:0] drive,
  output wire logic [7:0] pad_in
);
  // ==========================================
  // Pin resolution
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & drive);
endmodule // pag_board
`default_nettype wire

// File: bench/pag_port_bench.sv
// Purpose: Self-checking bench for pag_port
// Assumes: Inputs change on the falling edge
// Notes:   Pin reads wait 8 cycles for the synchroniser
`timescale 1ns/1ps
`default_nettype none
module pag_port_bench;
  logic       clk, rst_n, c1e, c1o, c2e, c2o, vre;
  logic       first_timer_clock_in, serial_slave_select_n;
  logic [3:0] stb, s;
  logic [2:0] osc_mode;
  logic [4:0] analog_select_bits;
  logic [7:0] wr_data, drive, pad_out, pad_oe;
  logic [7:0] pin_level_reg, output_latch_reg, direction_reg;
  wire  [7:0] pad_in;
  logic [7:0] periph;
  assign periph = {6'h0, serial_slave_select_n, first_timer_clock_in};
  int         err_count, n_compared;
  pag_port u_dut (.clk, .rst_n, .pin_level_reg_wr(stb[0]),
    .output_latch_reg_wr(stb[1]), .direction_reg_wr(stb[2]),
    .analog_select_reg_wr(stb[3]), .wr_data, .osc_mode,
    .first_comparator_oe(c1e), .first_comparator_out(c1o),
    .second_comparator_oe(c2e), .second_comparator_out(c2o),
    .comparator_ref_voltage_oe(vre), .pad_in, .pad_out, .pad_oe,
    .pin_level_reg, .output_latch_reg, .direction_reg,
    .analog_select_bits, .first_timer_clock_in, .serial_slave_select_n);
  pag_board u_brd (.pad_out, .pad_oe, .drive, .pad_in);
  // ==========================================
  // Tasks
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input int k, input logic [7:0] d);
    @(negedge clk);
    wr_data = d;
    stb[k] = 1'b1;
    @(negedge clk);
    stb = 4'h0;
  endtask
  task automatic ck(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Generous: the sequence needs about 100 cycles
  initial begin
    #20000;
    err_count++;
    close_out();
  end
  // ==========================================
  // Sequence
  initial begin
    rst_n = 1'b0;
    stb = 4'h0;
    wr_data = 8'h00;
    drive = 8'hff;
    osc_mode = pag_pkg::PAG_OSC_XTAL;
    {c1e, c1o, c2e, c2o, vre} = 5'h00;
    err_count = 0;
    n_compared = 0;
    wt(3);
    rst_n = 1'b1;
    wt(8);
    ck({3'h0, analog_select_bits}, 8'h1f);
    ck(direction_reg, 8'h3f);
    ck(pin_level_reg, 8'h10);
    ck(periph, 8'h03);
    osc_mode = pag_pkg::PAG_OSC_INT_IO;
    wr(3, 8'h00);
    wr(2, 8'hff);
    drive = 8'ha5;
    wt(8);
    ck(pin_level_reg, 8'ha5);
    wr(0, 8'h3c);
    wt(2);
    ck(output_latch_reg, 8'h3c);
    wr(1, 8'hc3);
    wr(2, 8'h0f);
    wt(2);
    ck(output_latch_reg, 8'hc3);
    ck(pad_oe, 8'hf0);
    ck(pad_out, 8'hc0);
    wt(8);
    ck(pin_level_reg, 8'hc5);
    ck(periph, 8'h00);
    {c1e, c1o, c2e, c2o} = 4'hf;
    wt(2);
    ck(pad_out, 8'hf0);
    vre = 1'b1;
    wr(2, 8'h00);
    wt(8);
    ck(pad_oe, 8'hfb);
    ck(pin_level_reg, 8'hf3);
    wr(3, 8'h1f);
    wt(8);
    ck(pad_out, 8'hf3);
    ck(pad_oe, 8'hfb);
    ck(pin_level_reg, 8'hd0);
    osc_mode = pag_pkg::PAG_OSC_RC_CLKO;
    wt(4);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      s[i] = pad_out[6];
    end
    ck({6'h0, pad_oe[6], s[0] ^ s[2]}, 8'h03);
    osc_mode = pag_pkg::PAG_OSC_EXT_IO;
    wr(2, 8'hff);
    wt(8);
    ck(direction_reg, 8'h7f);
    ck(output_latch_reg, 8'h43);
    // Remaining oscillator codes: ownership of pins six and seven
    osc_mode = pag_pkg::PAG_OSC_INT_CLKO;
    wt(6);
    ck(direction_reg, 8'hbf);
    ck(pad_oe, 8'h40);
    osc_mode = pag_pkg::PAG_OSC_RC_IO;
    wt(2);
    ck(direction_reg, 8'h7f);
    osc_mode = pag_pkg::PAG_OSC_EXT_CLKO;
    wt(6);
    ck(direction_reg, 8'h3f);
    ck(pad_oe, 8'h40);
    close_out();
  end
endmodule // pag_port_bench
`default_nettype wire
